// File: rtl/epfm_regs.svh
// Register offsets, field positions and timing figures of the energy pulse fault monitor.
`ifndef EPFM_REGS_SVH
`define EPFM_REGS_SVH

`define EPFM_ADR_STATUS      8'h00
`define EPFM_ADR_CTRL        8'h04
`define EPFM_ADR_CF_COUNT    8'h08
`define EPFM_STATUS_FAULT    0
`define EPFM_STATUS_NEUTRAL  1
`define EPFM_STATUS_SUPPR    2
`define EPFM_CTRL_PULSE_EN   0
`define EPFM_CTRL_RESET      32'h00000001

`define EPFM_CLK_HZ          125000000
`define EPFM_MASTER_HZ       3579000
`define EPFM_BASE_DIV_LOG2   21
`define EPFM_LPF_CORNER_MHZ  8900
`define EPFM_SLOW_WIDTH_MS   275
`define EPFM_SLOW_PERIOD_MS  550
`define EPFM_FAULT_DELAY_MS  1000
`define EPFM_CF_WIDTH_US     1000

`define EPFM_CF_MULT_BASE    8'h40
`define EPFM_FAULT_SHIFT     3
`define EPFM_SWAP_PCT        114
`define EPFM_PCT_BASE        100
`define EPFM_SUPPR_NUM       3
`define EPFM_SUPPR_DEN       1000
`define EPFM_FS_CODE         32767

`define EPFM_TF_X100         574
`define EPFM_FS_MV           660
`define EPFM_VREF_MV         2500
`define EPFM_CF_THR_BASE     (((64'h1 << (`EPFM_BASE_DIV_LOG2 + 24)) / \
  (64'(`EPFM_TF_X100) * `EPFM_FS_MV * `EPFM_FS_MV)) * \
  (64'(`EPFM_VREF_MV) * `EPFM_VREF_MV * `EPFM_PCT_BASE))

`endif

// File: rtl/epfm_pkg.sv
// Types shared by the energy pulse fault monitor.
package epfm_pkg;

  typedef struct packed {
    logic [1:0]         rate_s1;
    logic [1:0]         rate_s2;
    logic [1:0]         gain_s1;
    logic [1:0]         gain_s2;
    logic               scf_s1;
    logic               scf_s2;
    logic [31:0]        nco;
    logic               tick;
    logic signed [47:0] lpf;
    logic [63:0]        acc;
    logic [7:0]         cf_cnt;
    logic [31:0]        cf_total;
    logic [23:0]        cf_timer;
    logic               cf_n;
    logic [26:0]        period;
    logic [26:0]        slow_timer;
    logic               slow_sel;
    logic               a_n;
    logic               b_n;
    logic [31:0]        avg_p;
    logic [31:0]        avg_n;
    logic [26:0]        qual_timer;
    logic               fault;
    logic               neutral_active;
    logic               suppressed;
    logic               pulse_en;
    logic               ack;
    logic [31:0]        dat;
  } epfm_state_s;

endpackage

// File: rtl/epfm_energy_monitor.sv
// Energy to pulse conversion with phase and neutral current fault monitoring.
// Operation
// R1 - Integrate filtered power into output pulse rates.
// R2 - Power low-pass filter, first order, 8.9 Hz.
// R3 - Calibration pulses up to 128 times slow rate.
// R4 - Fault when current magnitudes differ over 12.5%.
// R5 - During fault, bill on the larger current.
// R6 - Phase current is billing input after reset.
// R7 - Startup imbalance: fault after ~1 s, maybe swap.
// R8 - No fault detection below 0.3% full scale.
// R9 - Neutral low: fault, keep billing on phase.
// R10 - Filter currents; fault follows about one second.
// R11 - Fault output independent of slow pulses.
// R12 - Neutral over 114%: fault and swap.
// R13 - Swap back only at phase over 114%.
// R14 - Fault clears once within 12.5%.
// R15 - Slow outputs give active-low energy pulses.
// R16 - Slow rate follows 5.74 transfer equation.
// R17 - Gain pins choose gain 1, 2, 8, 16.
// R18 - Rate pins choose 1.7 to 13.6 Hz.
// R19 - Base frequency is master clock over power two.
// R20 - Gain codes 00,01,10,11 give 1,2,8,16.
// R21 - Calibration multiple from scale and rate pins.
// R22 - Alternating 275 ms pulses, half period when short.
// R23 - Light load holds selection and fault state.
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "epfm_regs.svh"

module epfm_energy_monitor #(
  parameter int unsigned LPF_SHIFT        = 12,
  parameter int unsigned AVG_SHIFT        = 12,
  parameter logic [26:0] SLOW_WIDTH_CYC   = 27'(`EPFM_SLOW_WIDTH_MS * (`EPFM_CLK_HZ / 1000)),
  parameter logic [26:0] PERIOD_LIMIT_CYC = 27'(`EPFM_SLOW_PERIOD_MS * (`EPFM_CLK_HZ / 1000)),
  parameter logic [26:0] FAULT_DELAY_CYC  = 27'(`EPFM_FAULT_DELAY_MS * (`EPFM_CLK_HZ / 1000)),
  parameter logic [23:0] CF_WIDTH_CYC     = 24'(`EPFM_CF_WIDTH_US * (`EPFM_CLK_HZ / 1000000)),
  parameter logic [63:0] CF_THR           = `EPFM_CF_THR_BASE
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic                    wb_ack_o,
  output logic [31:0]             wb_dat_o,
  // Converter samples, same clock
  input  wire logic               sample_valid_i,
  input  wire logic signed [15:0] voltage_sample_i,
  input  wire logic signed [15:0] phase_current_input_i,
  input  wire logic signed [15:0] neutral_current_input_i,
  // Static select pins
  input  wire logic               rate_select_lsb_i,
  input  wire logic               rate_select_msb_i,
  input  wire logic               gain_select_lsb_i,
  input  wire logic               gain_select_msb_i,
  input  wire logic               calib_scale_select_i,
  // Pulse and fault outputs
  output logic                    energy_pulse_a_n_o,
  output logic                    energy_pulse_b_n_o,
  output logic                    calib_pulse_out_n_o,
  output logic                    fault_o,
  output logic                    neutral_active_o
);

  localparam logic [31:0] NCO_INC =
    32'((64'(`EPFM_MASTER_HZ) << 32) / 64'(`EPFM_CLK_HZ));

  function automatic logic [2:0] gain_shift(input logic [1:0] code);
    unique case (code)
      2'h0: gain_shift = 3'h0;
      2'h1: gain_shift = 3'h1;
      2'h2: gain_shift = 3'h3;
      2'h3: gain_shift = 3'h4;
    endcase
  endfunction

  function automatic logic [15:0] magnitude(input logic signed [15:0] x);
    magnitude = x[15] ? 16'(-x) : 16'(x);
  endfunction

  epfm_pkg::epfm_state_s st;
  epfm_pkg::epfm_state_s next_st;

  logic signed [31:0] prod;
  logic signed [31:0] lpf_out;
  logic [63:0]        gained;
  logic [63:0]        acc_sum;
  logic [63:0]        cf_thr;
  logic [7:0]         cf_mult;
  logic               cf_event;
  logic               slow_event;
  logic [15:0]        ap;
  logic [15:0]        an;
  logic [15:0]        hi;
  logic [15:0]        lo;
  logic               fault_cond;
  logic               swap_cond;
  logic               suppress;
  logic [26:0]        width;

  always_comb begin
    next_st = st;
    next_st.rate_s1 = {rate_select_msb_i, rate_select_lsb_i};
    next_st.rate_s2 = st.rate_s1;
    next_st.gain_s1 = {gain_select_msb_i, gain_select_lsb_i};
    next_st.gain_s2 = st.gain_s1;
    next_st.scf_s1  = calib_scale_select_i;
    next_st.scf_s2  = st.scf_s1;

    // The master clock is rebuilt as a tick from a phase accumulator; dividing it by
    // two to the 21 down to 18 gives the base frequencies.
    {next_st.tick, next_st.nco} = {1'b0, st.nco} + {1'b0, NCO_INC}; // R19

    // Billing current is the one currently selected by the fault logic.
    prod = 32'(voltage_sample_i *
      (st.neutral_active ? neutral_current_input_i : phase_current_input_i)); // R5 R6
    if (sample_valid_i) begin
      next_st.lpf = st.lpf + 48'(prod) - (st.lpf >>> LPF_SHIFT); // R2
      next_st.avg_p = st.avg_p + 32'(magnitude(phase_current_input_i)) -
        (st.avg_p >> AVG_SHIFT); // R10
      next_st.avg_n = st.avg_n + 32'(magnitude(neutral_current_input_i)) -
        (st.avg_n >> AVG_SHIFT); // R10
    end
    lpf_out = 32'(st.lpf >>> LPF_SHIFT);

    // Negative power is not billed; gain enters as a shift of the filtered power.
    gained = lpf_out[31] ? 64'h0 :
      (64'(lpf_out[30:0]) << gain_shift(st.gain_s2)); // R17 R20
    // The calibration threshold does not depend on the rate pins: the rate only sets
    // how many calibration pulses make one slow pulse.
    cf_thr  = CF_THR >> st.scf_s2; // R16
    cf_mult = (`EPFM_CF_MULT_BASE << st.scf_s2) >> st.rate_s2; // R3 R18 R21
    acc_sum = st.acc + gained;
    cf_event   = 1'b0;
    slow_event = 1'b0;
    if (st.pulse_en && st.tick) begin
      if (acc_sum >= cf_thr) begin
        next_st.acc = acc_sum - cf_thr; // R1
        cf_event = 1'b1;
      end else begin
        next_st.acc = acc_sum; // R1
      end
    end
    if (cf_event) begin
      next_st.cf_total = st.cf_total + 32'h1;
      if (st.cf_cnt >= cf_mult - 8'h1) begin
        next_st.cf_cnt = 8'h0; // R3 R21
        slow_event = 1'b1;
      end else begin
        next_st.cf_cnt = st.cf_cnt + 8'h1;
      end
    end

    if (cf_event) begin
      next_st.cf_n = 1'b0;
      next_st.cf_timer = CF_WIDTH_CYC;
    end else if (st.cf_timer != 24'h0) begin
      next_st.cf_timer = st.cf_timer - 24'h1;
      next_st.cf_n = (st.cf_timer == 24'h1);
    end

    // Slow pulses alternate between the two outputs; a new pulse ends the other one
    // so that both are never low together.
    width = (st.period < PERIOD_LIMIT_CYC) ? (st.period >> 1) : SLOW_WIDTH_CYC; // R22
    if (width == 27'h0) begin
      width = 27'h1;
    end
    if (st.period != {27{1'b1}}) begin
      next_st.period = st.period + 27'h1;
    end
    if (slow_event) begin
      next_st.period = 27'h0;
      next_st.slow_sel = !st.slow_sel;
      next_st.a_n = st.slow_sel; // R15 R22
      next_st.b_n = !st.slow_sel; // R15 R22
      next_st.slow_timer = width;
    end else if (st.slow_timer != 27'h0) begin
      next_st.slow_timer = st.slow_timer - 27'h1;
      if (st.slow_timer == 27'h1) begin
        next_st.a_n = 1'b1;
        next_st.b_n = 1'b1;
      end
    end
    if (!st.pulse_en) begin
      next_st.cf_n = 1'b1;
      next_st.a_n = 1'b1;
      next_st.b_n = 1'b1;
      next_st.slow_timer = 27'h0;
      next_st.cf_timer = 24'h0;
    end

    // Fault monitor works on averaged magnitudes and never looks at the pulse path.
    ap = 16'(st.avg_p >> AVG_SHIFT);
    an = 16'(st.avg_n >> AVG_SHIFT);
    hi = (ap > an) ? ap : an;
    lo = (ap > an) ? an : ap;
    fault_cond = (32'(hi - lo) << `EPFM_FAULT_SHIFT) > 32'(hi); // R4 R9 R14
    swap_cond = st.neutral_active ?
      (32'(ap) * `EPFM_PCT_BASE > 32'(an) * `EPFM_SWAP_PCT) :
      (32'(an) * `EPFM_PCT_BASE > 32'(ap) * `EPFM_SWAP_PCT); // R12 R13
    suppress = 32'(hi) * `EPFM_SUPPR_DEN < 32'(`EPFM_SUPPR_NUM * `EPFM_FS_CODE); // R8
    next_st.suppressed = suppress;
    if (suppress) begin
      next_st.qual_timer = 27'h0; // R23
    end else begin
      if (!fault_cond) begin
        next_st.fault = 1'b0; // R14
      end
      if ((fault_cond && !st.fault) || swap_cond) begin
        // Assertion and swap wait for a second of persistent imbalance, which keeps
        // mains noise from flipping the billing input.
        if (st.qual_timer >= FAULT_DELAY_CYC - 27'h1) begin
          next_st.qual_timer = 27'h0;
          next_st.fault = 1'b1; // R7 R9 R10 R12
          if (swap_cond) begin
            next_st.neutral_active = !st.neutral_active; // R7 R12 R13
          end
        end else begin
          next_st.qual_timer = st.qual_timer + 27'h1;
        end
      end else begin
        next_st.qual_timer = 27'h0;
      end
    end

    next_st.ack = wb_cyc_i && wb_stb_i && !st.ack;
    next_st.dat = 32'h0;
    if (wb_cyc_i && wb_stb_i && !st.ack) begin
      if (wb_we_i) begin
        if (wb_adr_i == `EPFM_ADR_CTRL && wb_sel_i[0]) begin
          next_st.pulse_en = wb_dat_i[`EPFM_CTRL_PULSE_EN];
        end
      end else begin
        unique case (wb_adr_i)
          `EPFM_ADR_STATUS: begin
            next_st.dat[`EPFM_STATUS_FAULT]   = st.fault;
            next_st.dat[`EPFM_STATUS_NEUTRAL] = st.neutral_active;
            next_st.dat[`EPFM_STATUS_SUPPR]   = st.suppressed;
          end
          `EPFM_ADR_CTRL: next_st.dat[`EPFM_CTRL_PULSE_EN] = st.pulse_en;
          `EPFM_ADR_CF_COUNT: next_st.dat = st.cf_total;
          default: next_st.dat = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st                <= '0;
      st.cf_n           <= 1'b1;
      st.a_n            <= 1'b1;
      st.b_n            <= 1'b1;
      st.neutral_active <= 1'b0; // R6
      st.pulse_en       <= 1'(`EPFM_CTRL_RESET);
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o            = st.ack;
  assign wb_dat_o            = st.dat;
  assign energy_pulse_a_n_o  = st.a_n;
  assign energy_pulse_b_n_o  = st.b_n;
  assign calib_pulse_out_n_o = st.cf_n;
  assign fault_o             = st.fault; // R11
  assign neutral_active_o    = st.neutral_active;

  property p_phase_after_reset;
    @(posedge clk_i) $fell(rst_i) |-> !st.neutral_active && !st.fault;
  endproperty
  a_phase_after_reset: assert property (p_phase_after_reset) // R6
    else $error("billing input is not phase after reset");

  property p_tick_spacing;
    @(posedge clk_i) disable iff (rst_i) st.tick |=> !st.tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) // R19
    else $error("master ticks arrive too close together");

  property p_slow_from_cf;
    @(posedge clk_i) disable iff (rst_i)
      ($fell(st.a_n) || $fell(st.b_n)) |->
        $past(cf_event) && ($past(st.cf_cnt) == $past(cf_mult) - 8'h1);
  endproperty
  a_slow_from_cf: assert property (p_slow_from_cf) // R3
    else $error("slow pulse not after the calibration multiple");

  property p_alternate;
    @(posedge clk_i) disable iff (rst_i) $fell(st.a_n) |-> st.b_n ##0 $past(st.slow_sel) == 1'b0;
  endproperty
  a_alternate: assert property (p_alternate) // R22
    else $error("slow outputs do not alternate");

  property p_clear_fault;
    @(posedge clk_i) disable iff (rst_i) (st.fault && !fault_cond && !suppress) |=> !st.fault;
  endproperty
  a_clear_fault: assert property (p_clear_fault) // R14
    else $error("fault not cleared when currents agree");

  property p_hold_light;
    @(posedge clk_i) disable iff (rst_i)
      suppress |=> $stable(st.fault) && $stable(st.neutral_active);
  endproperty
  a_hold_light: assert property (p_hold_light) // R23
    else $error("state changed while detection suppressed");

  property p_swap_fault;
    @(posedge clk_i) disable iff (rst_i)
      $changed(st.neutral_active) |-> st.fault && $past(swap_cond) && !$past(suppress);
  endproperty
  a_swap_fault: assert property (p_swap_fault) // R12
    else $error("swap without fault or without 114 percent excess");

  property p_no_swap_low;
    @(posedge clk_i) disable iff (rst_i)
      (!st.neutral_active && !swap_cond) |=> !st.neutral_active;
  endproperty
  a_no_swap_low: assert property (p_no_swap_low) // R9
    else $error("swapped to neutral while it is not larger");

  property p_fault_qualified;
    @(posedge clk_i) disable iff (rst_i)
      $rose(st.fault) |-> $past(st.qual_timer) == FAULT_DELAY_CYC - 27'h1;
  endproperty
  a_fault_qualified: assert property (p_fault_qualified) // R10
    else $error("fault raised before the averaging delay");

  property p_wb_ack;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !st.ack) |=> st.ack ##1 !st.ack;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("wishbone ack not a single cycle after request");

  property p_cf_width;
    @(posedge clk_i) disable iff (rst_i)
      cf_event |=> !st.cf_n && st.cf_timer == CF_WIDTH_CYC;
  endproperty
  a_cf_width: assert property (p_cf_width) // R3
    else $error("calibration pulse not started at full width");

  property p_event_on_tick;
    @(posedge clk_i) disable iff (rst_i) cf_event |-> st.tick && st.pulse_en;
  endproperty
  a_event_on_tick: assert property (p_event_on_tick) // R19
    else $error("calibration event away from a master tick");

  property p_slow_width;
    @(posedge clk_i) disable iff (rst_i)
      slow_event |=> st.slow_timer != 27'h0 && st.slow_timer <= SLOW_WIDTH_CYC;
  endproperty
  a_slow_width: assert property (p_slow_width) // R22
    else $error("slow pulse width out of range");

  property p_slow_not_both;
    @(posedge clk_i) disable iff (rst_i) st.a_n || st.b_n;
  endproperty
  a_slow_not_both: assert property (p_slow_not_both) // R15
    else $error("both slow outputs low together");

  property p_fault_cause;
    @(posedge clk_i) disable iff (rst_i)
      $rose(st.fault) |-> $past(fault_cond) || $past(swap_cond);
  endproperty
  a_fault_cause: assert property (p_fault_cause) // R4
    else $error("fault raised without current imbalance");

  // Disabling pulses must leave every pulse output idle, or a counter could step.
  property p_idle_when_off;
    @(posedge clk_i) disable iff (rst_i) !st.pulse_en |=> st.a_n && st.b_n && st.cf_n;
  endproperty
  a_idle_when_off: assert property (p_idle_when_off)
    else $error("pulse output active while pulses are disabled");

endmodule // epfm_energy_monitor

// File: test/epfm_pulse_counter.sv
// Model of the stepper or impulse counter that the slow energy outputs drive.
`timescale 1ns/10ps

module epfm_pulse_counter (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Slow energy pulses, active low
  input  wire logic pulse_a_n_i,
  input  wire logic pulse_b_n_i,
  // Count of ordering faults seen
  output int        bad_o
);
  logic last_b;
  logic a_q;
  logic b_q;

  // A two-phase stepper loses a step if both coils are driven together.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bad_o  <= 0;
      last_b <= 1'b1;
      a_q    <= 1'b1;
      b_q    <= 1'b1;
    end else begin
      a_q <= pulse_a_n_i;
      b_q <= pulse_b_n_i;
      if (!pulse_a_n_i && !pulse_b_n_i) begin
        bad_o <= bad_o + 1;
      end else if (a_q && !pulse_a_n_i) begin
        bad_o  <= last_b ? bad_o : bad_o + 1;
        last_b <= 1'b0;
      end else if (b_q && !pulse_b_n_i) begin
        bad_o  <= last_b ? bad_o + 1 : bad_o;
        last_b <= 1'b1;
      end
    end
  end
endmodule // epfm_pulse_counter

// File: test/epfm_energy_monitor_tb.sv
// Self-checking bench for the energy pulse fault monitor.
`timescale 1ns/10ps
`include "epfm_regs.svh"

module epfm_energy_monitor_tb;
  logic               clk;
  logic               rst;
  logic               cyc;
  logic               stb;
  logic               we;
  logic [7:0]         adr;
  logic [31:0]        wdat;
  logic               ack;
  logic [31:0]        rdat;
  logic               sv;
  logic signed [15:0] volt;
  logic signed [15:0] cp;
  logic signed [15:0] cn;
  logic [4:0]         pins;
  logic [3:0]         sel;
  logic               cf_q;
  logic               slow_q;
  logic               pa_n;
  logic               pb_n;
  logic               cf_n;
  logic               fault;
  logic               neut;
  logic [31:0]        r;
  int                 tgt_p = 0;
  int                 tgt_n = 0;
  int                 seed = 78;
  int                 jseed = 78;
  int                 n_fail = 0;
  int                 n_checks = 0;
  int                 cycles = 0;
  int                 bad;
  int                 a;
  int                 n_cf = 0;
  int                 n_slow = 0;

  epfm_energy_monitor #(
    .LPF_SHIFT       (2),
    .AVG_SHIFT       (2),
    .SLOW_WIDTH_CYC  (27'h28),
    .PERIOD_LIMIT_CYC(27'h50),
    .FAULT_DELAY_CYC (27'h32),
    .CF_WIDTH_CYC    (24'h4),
    .CF_THR          (64'h0000000008000000)
  ) i_epfm_energy_monitor (
    .clk_i                  (clk),
    .rst_i                  (rst),
    .wb_cyc_i               (cyc),
    .wb_stb_i               (stb),
    .wb_we_i                (we),
    .wb_adr_i               (adr),
    .wb_sel_i               (sel),
    .wb_dat_i               (wdat),
    .wb_ack_o               (ack),
    .wb_dat_o               (rdat),
    .sample_valid_i         (sv),
    .voltage_sample_i       (volt),
    .phase_current_input_i  (cp),
    .neutral_current_input_i(cn),
    .rate_select_lsb_i      (pins[0]),
    .rate_select_msb_i      (pins[1]),
    .gain_select_lsb_i      (pins[2]),
    .gain_select_msb_i      (pins[3]),
    .calib_scale_select_i   (pins[4]),
    .energy_pulse_a_n_o     (pa_n),
    .energy_pulse_b_n_o     (pb_n),
    .calib_pulse_out_n_o    (cf_n),
    .fault_o                (fault),
    .neutral_active_o       (neut)
  );

  epfm_pulse_counter i_epfm_pulse_counter (
    .clk_i      (clk),
    .rst_i      (rst),
    .pulse_a_n_i(pa_n),
    .pulse_b_n_i(pb_n),
    .bad_o      (bad)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Jittered samples keep the averaging honest instead of feeding it constants.
  always @(posedge clk) begin
    sv   <= (cycles % 4) == 0;
    volt <= 16'(20000 + $random(jseed) % 4000);
    cp   <= 16'(tgt_p + $random(jseed) % 32);
    cn   <= 16'(tgt_n + $random(jseed) % 32);
  end

  // Falling edges of the calibration output and of the slow pair, counted since reset.
  always @(posedge clk) begin
    cf_q   <= cf_n;
    slow_q <= pa_n && pb_n;
    if (rst) begin
      n_cf   <= 0;
      n_slow <= 0;
    end else begin
      if (cf_q && !cf_n) begin
        n_cf <= n_cf + 1;
      end
      if (slow_q && !(pa_n && pb_n)) begin
        n_slow <= n_slow + 1;
      end
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= ad;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
    chk(32'(n < 20), 32'h1);
  endtask

  // Calibration pulses per slow pulse, from the scale and rate pins.
  function automatic int exp_mult(input logic [4:0] p);
    exp_mult = (p[4] ? 128 : 64) >> p[1:0];
  endfunction

  // The count before the first slow pulse may be partial, so it is skipped.
  task automatic cf_per_slow(input int want);
    int k;
    int s0;
    int c0;
    k = 0;
    s0 = n_slow;
    while (n_slow == s0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    c0 = n_cf;
    s0 = n_slow;
    while (n_slow == s0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    chk(32'(k < 20000), 32'h1);
    chk(32'(n_cf - c0), 32'(want));
  endtask

  // Drives the two current levels, waits for the expected outputs, then holds on.
  task automatic settle(input int p, input int n, input logic f, input logic na,
                        input int hold);
    int k;
    tgt_p = p;
    tgt_n = n;
    k = 0;
    while ((fault !== f || neut !== na) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    repeat (hold) @(posedge clk);
    chk({30'h0, fault, neut}, {30'h0, f, na});
  endtask

  initial begin
    rst  = 1'b1;
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 8'h00;
    wdat = 32'h0;
    sv   = 1'b0;
    volt = 16'h0;
    cp   = 16'h0;
    cn   = 16'h0;
    sel  = 4'hF;
    pins = 5'($random(seed));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({29'h0, pa_n, pb_n, cf_n}, 32'h7);
    chk({30'h0, fault, neut}, 32'h0);
    wb(1'b0, `EPFM_ADR_CTRL, 32'h0);
    chk(r, `EPFM_CTRL_RESET);
    sel <= 4'hE;
    wb(1'b1, `EPFM_ADR_CTRL, 32'h0);
    sel <= 4'hF;
    wb(1'b0, `EPFM_ADR_CTRL, 32'h0);
    chk(r, `EPFM_CTRL_RESET);
    wb(1'b1, `EPFM_ADR_STATUS, 32'hFFFFFFFF);
    wb(1'b0, `EPFM_ADR_STATUS, 32'h0);
    chk(r, 32'h4);
    wb(1'b0, 8'hFC, 32'h0);
    chk(r, 32'h0);
    settle(20000, 20000, 1'b0, 1'b0, 400);
    cf_per_slow(exp_mult(pins));
    settle(0, 60, 1'b0, 1'b0, 400);
    wb(1'b0, `EPFM_ADR_STATUS, 32'h0);
    chk(r, 32'h4);
    tgt_p = 20000;
    tgt_n = 10000;
    repeat (30) @(posedge clk);
    chk({31'h0, fault}, 32'h0);
    settle(20000, 10000, 1'b1, 1'b0, 100);
    wb(1'b1, `EPFM_ADR_CTRL, 32'h0);
    settle(20000, 10000, 1'b1, 1'b0, 200);
    chk({29'h0, pa_n, pb_n, cf_n}, 32'h7);
    wb(1'b0, `EPFM_ADR_STATUS, 32'h0);
    chk(r, 32'h1);
    wb(1'b0, `EPFM_ADR_CF_COUNT, 32'h0);
    chk(r, 32'(n_cf));
    wb(1'b1, `EPFM_ADR_CTRL, 32'h1);
    settle(20000, 20000, 1'b0, 1'b0, 50);
    settle(20000, 30000, 1'b1, 1'b1, 50);
    wb(1'b0, `EPFM_ADR_STATUS, 32'h0);
    chk(r, 32'h3);
    settle(28000, 30000, 1'b0, 1'b1, 400);
    settle(28000, 20000, 1'b1, 1'b0, 50);
    for (int i = 0; i < 4; i++) begin
      a = 5000 + int'($unsigned($random(seed)) % 25000);
      settle(a, a + a / 32, 1'b0, 1'b0, 100);
    end
    tgt_p = 0;
    tgt_n = 20000;
    rst <= 1'b1;
    pins <= {1'b0, 2'($random(seed)), 2'h3};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    settle(0, 20000, 1'b1, 1'b1, 50);
    cf_per_slow(exp_mult(pins));
    chk(32'(bad), 32'h0);
    give_verdict();
  end
endmodule // epfm_energy_monitor_tb
